// >>> logic/phy_link_pkg.sv
/*
 * Shared constants and types for the MAC-facing data link of a
 * 10/100/1000 transceiver: link modes, transmit symbol kinds and clock
 * rates.
 * Assumes both ends run on one 100 MHz system clock, and that each
 * link clock is either made here by a divider or sampled as a plain input.
 */
package phy_link_pkg;

  typedef enum logic [3:0] {
    MODE_MII10  = 4'h1,
    MODE_MII100 = 4'h2,
    MODE_GMII   = 4'h4,
    MODE_RGMII  = 4'h8
  } mode_e;

  typedef enum logic [2:0] {
    SYM_DATA    = 3'h1,
    SYM_INVALID = 3'h2,
    SYM_HALT    = 3'h4
  } sym_e;

  localparam int MCLK_KHZ = 100000;
  localparam int CLK10_KHZ = 2500;
  localparam int CLK100_KHZ = 25000;
  localparam int CLK1000_KHZ = 125000;
  localparam int DIV_W = 8;

  // half period in system cycles, rounded down, never below one
  function automatic int half_cycles(int khz);
    int h;
    h = MCLK_KHZ / (2 * khz);
    return (h < 1) ? 1 : h;
  endfunction

  localparam int HALF_10 = half_cycles(CLK10_KHZ);
  localparam int HALF_100 = half_cycles(CLK100_KHZ);
  localparam int HALF_1000 = half_cycles(CLK1000_KHZ);

endpackage

// >>> logic/phy_link_if.sv
/*
 * Link wires between the transceiver end and the MAC end.
 * Assumes both ends share one system clock; the link clocks here are
 * plain signals that each receiving end samples and edge-detects.
 */
interface phy_link_if;
  logic tx_clk;
  logic gtx_clk;
  logic rx_clk;
  logic [7:0] tx_d;
  logic tx_en_ctrl;
  logic tx_er;
  logic [3:0] rx_d;
  logic rx_dv_ctrl;

  modport phy (
    output tx_clk,
    output rx_clk,
    output rx_d,
    output rx_dv_ctrl,
    input gtx_clk,
    input tx_d,
    input tx_en_ctrl,
    input tx_er
  );

  modport mac (
    input tx_clk,
    input rx_clk,
    input rx_d,
    input rx_dv_ctrl,
    output gtx_clk,
    output tx_d,
    output tx_en_ctrl,
    output tx_er
  );
endinterface

// >>> logic/phy_end.sv
/*
 * Transceiver end of the MAC data link: makes the MII transmit clock and
 * the receive clock, captures transmit lanes from the MAC into symbols,
 * and drives receive lanes toward the MAC in MII, GMII and RGMII modes.
 * Assumes mclk at 100 MHz, the MAC end on the far side of phy_link_if,
 * and a user side on the same clock as this block.
 */
// Notes on behaviour
// - MII mode: transmit clock always runs free
// - transmit clock 2.5 or 25 MHz by speed
// - MII transmit lanes launched and captured on tx_clk
// - upper transmit lanes only in GMII, on gtx_clk
// - GMII/RGMII low transmit lanes timed by gtx_clk
// - MII low transmit lanes timed by tx_clk
// - GMII transmit error timed by gtx_clk
// - MII error: invalid then halt until release
// - GMII error: at least one invalid code-group
// - MAC supplies continuous 125 MHz gtx_clk; mac_end makes 50 MHz at the default HALF1000 of 1
// - receive clock 2.5, 25 or 125 MHz; here 2.5, 25 or 50 MHz at the default half periods
// - low receive lanes driven on rx_clk
// - MAC raises enable while lanes carry data
// - RGMII control: enable rising, error falling
// - receive valid high while lanes carry data
// - RGMII receive control: valid rising, error falling
module phy_end #(
  parameter int HALF10 = phy_link_pkg::HALF_10,
  parameter int HALF100 = phy_link_pkg::HALF_100,
  parameter int HALF1000 = phy_link_pkg::HALF_1000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire phy_link_pkg::mode_e mode,
  phy_link_if.phy lnk,
  output logic [7:0] tx_data,
  output phy_link_pkg::sym_e tx_sym,
  output logic tx_strobe,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_err,
  output logic rx_take
);
  import phy_link_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic clk_ph;
    logic tx_clk;
    logic rx_clk;
    logic gtx_s1;
    logic gtx_s2;
    logic gtx_s3;
    logic [7:0] txd_s1;
    logic [7:0] txd_s2;
    logic [7:0] txd_s3;
    logic en_s1;
    logic en_s2;
    logic en_s3;
    logic er_s1;
    logic er_s2;
    logic er_s3;
    logic [3:0] lo_nib;
    logic lo_en;
    logic err_run;
    logic [7:0] tx_data;
    sym_e tx_sym;
    logic tx_strobe;
    logic [3:0] rx_d;
    logic rx_ctl;
    logic [3:0] rx_hi;
    logic rx_er_hold;
    logic rx_take;
  } phy_s;

  localparam phy_s PHY_RST = '{
    div_cnt: '0, clk_ph: 1'b0, tx_clk: 1'b0, rx_clk: 1'b0,
    gtx_s1: 1'b0, gtx_s2: 1'b0, gtx_s3: 1'b0,
    txd_s1: 8'h00, txd_s2: 8'h00, txd_s3: 8'h00, en_s1: 1'b0,
    en_s2: 1'b0, en_s3: 1'b0, er_s1: 1'b0, er_s2: 1'b0, er_s3: 1'b0,
    lo_nib: 4'h0, lo_en: 1'b0,
    err_run: 1'b0, tx_data: 8'h00, tx_sym: SYM_DATA, tx_strobe: 1'b0,
    rx_d: 4'h0, rx_ctl: 1'b0, rx_hi: 4'h0, rx_er_hold: 1'b0,
    rx_take: 1'b0
  };

  phy_s st_r;
  phy_s st_nxt;

  // last count of a half period for the current speed
  function automatic logic [DIV_W-1:0] half_last(mode_e m);
    int h;
    case (m)
      MODE_MII10: h = HALF10;
      MODE_MII100: h = HALF100;
      default: h = HALF1000;
    endcase
    return DIV_W'(h - 1);
  endfunction

  logic mii;
  logic rgmii;
  logic toggle;
  logic rise_own;
  logic fall_own;
  logic g_rise;
  logic g_fall;
  logic cap_rise;
  logic cap_fall;

  always_comb begin
    mii = (mode == MODE_MII10) || (mode == MODE_MII100);
    rgmii = (mode == MODE_RGMII);
    toggle = (st_r.div_cnt >= half_last(mode));
    rise_own = toggle && !st_r.clk_ph;
    fall_own = toggle && st_r.clk_ph;
    // only the second and third gtx flops feed the edge detector
    g_rise = st_r.gtx_s2 && !st_r.gtx_s3;
    g_fall = !st_r.gtx_s2 && st_r.gtx_s3;
    cap_rise = mii ? rise_own : g_rise;
    cap_fall = rgmii && g_fall;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_strobe = 1'b0;
    st_nxt.rx_take = 1'b0;

    // one divider serves both clocks; it never stops, so in MII the
    // transmit clock keeps running between frames
    st_nxt.div_cnt = toggle ? '0 : st_r.div_cnt + 1'b1;
    if (toggle) begin
      st_nxt.clk_ph = !st_r.clk_ph;
    end
    st_nxt.rx_clk = st_nxt.clk_ph;
    st_nxt.tx_clk = mii ? st_nxt.clk_ph : 1'b0;

    st_nxt.gtx_s1 = lnk.gtx_clk;
    st_nxt.gtx_s2 = st_r.gtx_s1;
    st_nxt.gtx_s3 = st_r.gtx_s2;
    st_nxt.txd_s1 = lnk.tx_d;
    st_nxt.txd_s2 = st_r.txd_s1;
    st_nxt.en_s1 = lnk.tx_en_ctrl;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.er_s1 = lnk.tx_er;
    st_nxt.er_s2 = st_r.er_s1;
    // lanes take one stage more than the clock edge detector, so the
    // capture sees the value from before the edge; needed in RGMII where
    // lanes move on both edges; MII then needs half periods of 7 or more
    st_nxt.txd_s3 = st_r.txd_s2;
    st_nxt.en_s3 = st_r.en_s2;
    st_nxt.er_s3 = st_r.er_s2;

    if (cap_rise) begin
      if (mii) begin
        // nibble lanes only; upper lanes ignored outside GMII
        st_nxt.tx_data = {4'h0, st_r.txd_s3[3:0]};
        st_nxt.tx_strobe = st_r.en_s3 || st_r.er_s3;
        st_nxt.err_run = st_r.er_s3;
        if (st_r.er_s3) begin
          st_nxt.tx_sym = st_r.err_run ? SYM_HALT : SYM_INVALID;
        end else begin
          st_nxt.tx_sym = SYM_DATA;
        end
      end else if (rgmii) begin
        st_nxt.lo_nib = st_r.txd_s3[3:0];
        st_nxt.lo_en = st_r.en_s3;
      end else begin
        st_nxt.tx_data = st_r.txd_s3;
        st_nxt.tx_strobe = st_r.en_s3 || st_r.er_s3;
        // every errored cycle becomes an invalid code-group
        st_nxt.tx_sym = st_r.er_s3 ? SYM_INVALID : SYM_DATA;
        st_nxt.err_run = 1'b0;
      end
    end

    if (cap_fall) begin
      st_nxt.tx_data = {st_r.txd_s3[3:0], st_r.lo_nib};
      st_nxt.tx_strobe = st_r.lo_en || st_r.en_s3;
      st_nxt.tx_sym = st_r.en_s3 ? SYM_INVALID : SYM_DATA;
      st_nxt.err_run = 1'b0;
    end

    // receive lanes change on the falling edge, RGMII high nibble on rising, so the MAC, which samples
    // data one stage behind its clock edge detector, sees them stable at each capture edge
    if (fall_own) begin
      st_nxt.rx_d = rx_data[3:0];
      st_nxt.rx_ctl = rx_valid;
      st_nxt.rx_hi = rx_data[7:4];
      st_nxt.rx_er_hold = rx_err;
      st_nxt.rx_take = 1'b1;
    end
    if (rise_own && rgmii) begin
      st_nxt.rx_d = st_r.rx_hi;
      st_nxt.rx_ctl = st_r.rx_er_hold;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= PHY_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.tx_clk = st_r.tx_clk;
  assign lnk.rx_clk = st_r.rx_clk;
  assign lnk.rx_d = st_r.rx_d;
  assign lnk.rx_dv_ctrl = st_r.rx_ctl;
  assign tx_data = st_r.tx_data;
  assign tx_sym = st_r.tx_sym;
  assign tx_strobe = st_r.tx_strobe;
  assign rx_take = st_r.rx_take;

endmodule

// >>> logic/mac_end.sv
/*
 * MAC end of the data link: makes the gigabit transmit clock, launches
 * transmit lanes in MII, GMII and RGMII modes, and captures receive lanes.
 * Assumes mclk at 100 MHz, the transceiver end across phy_link_if, and a
 * user side on the same clock.
 */
module mac_end #(
  parameter int HALF1000 = phy_link_pkg::HALF_1000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire phy_link_pkg::mode_e mode,
  phy_link_if.mac lnk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_error,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  output logic rx_strobe
);
  import phy_link_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic gtx;
    logic txc_s1;
    logic txc_s2;
    logic txc_s3;
    logic rxc_s1;
    logic rxc_s2;
    logic rxc_s3;
    logic [3:0] rxd_s1;
    logic [3:0] rxd_s2;
    logic [3:0] rxd_s3;
    logic ctl_s1;
    logic ctl_s2;
    logic ctl_s3;
    logic [7:0] tx_d;
    logic tx_ctl;
    logic tx_er;
    logic [3:0] hi_nib;
    logic er_hold;
    logic tx_take;
    logic [3:0] lo_nib;
    logic lo_dv;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_err;
    logic rx_strobe;
  } mac_s;

  mac_s st_r;
  mac_s st_nxt;

  logic mii;
  logic rgmii;
  logic toggle;
  logic own_rise;
  logic own_fall;
  logic t_fall;
  logic r_rise;
  logic r_fall;

  always_comb begin
    mii = (mode == MODE_MII10) || (mode == MODE_MII100);
    rgmii = (mode == MODE_RGMII);
    toggle = (st_r.div_cnt >= DIV_W'(HALF1000 - 1));
    own_rise = toggle && !st_r.gtx;
    own_fall = toggle && st_r.gtx;
    t_fall = !st_r.txc_s2 && st_r.txc_s3;
    r_rise = st_r.rxc_s2 && !st_r.rxc_s3;
    r_fall = !st_r.rxc_s2 && st_r.rxc_s3;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_take = 1'b0;
    st_nxt.rx_strobe = 1'b0;

    // gtx runs in every mode so the transceiver never loses it
    st_nxt.div_cnt = toggle ? '0 : st_r.div_cnt + 1'b1;
    if (toggle) begin
      st_nxt.gtx = !st_r.gtx;
    end

    st_nxt.txc_s1 = lnk.tx_clk;
    st_nxt.txc_s2 = st_r.txc_s1;
    st_nxt.txc_s3 = st_r.txc_s2;
    st_nxt.rxc_s1 = lnk.rx_clk;
    st_nxt.rxc_s2 = st_r.rxc_s1;
    st_nxt.rxc_s3 = st_r.rxc_s2;
    st_nxt.rxd_s1 = lnk.rx_d;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.ctl_s1 = lnk.rx_dv_ctrl;
    st_nxt.ctl_s2 = st_r.ctl_s1;
    // one stage more than the edge detector: capture sees the lanes as
    // they stood before the edge, as RGMII moves them on both edges
    st_nxt.rxd_s3 = st_r.rxd_s2;
    st_nxt.ctl_s3 = st_r.ctl_s2;

    // launch on falling edges, RGMII high nibble on rising, so lanes are settled at each capture edge
    if (mii && t_fall) begin
      st_nxt.tx_d = {4'h0, tx_data[3:0]};
      st_nxt.tx_ctl = tx_valid;
      st_nxt.tx_er = tx_error;
      st_nxt.tx_take = 1'b1;
    end else if (mode == MODE_GMII && own_fall) begin
      st_nxt.tx_d = tx_data;
      st_nxt.tx_ctl = tx_valid;
      st_nxt.tx_er = tx_error;
      st_nxt.tx_take = 1'b1;
    end else if (rgmii && own_fall) begin
      st_nxt.tx_d = {4'h0, tx_data[3:0]};
      st_nxt.tx_ctl = tx_valid;
      st_nxt.tx_er = 1'b0;
      st_nxt.hi_nib = tx_data[7:4];
      st_nxt.er_hold = tx_error;
      st_nxt.tx_take = 1'b1;
    end else if (rgmii && own_rise) begin
      st_nxt.tx_d = {4'h0, st_r.hi_nib};
      st_nxt.tx_ctl = st_r.er_hold;
    end

    if (r_rise) begin
      if (rgmii) begin
        st_nxt.lo_nib = st_r.rxd_s3;
        st_nxt.lo_dv = st_r.ctl_s3;
      end else begin
        st_nxt.rx_data = {4'h0, st_r.rxd_s3};
        st_nxt.rx_valid = st_r.ctl_s3;
        st_nxt.rx_err = 1'b0;
        st_nxt.rx_strobe = 1'b1;
      end
    end
    if (r_fall && rgmii) begin
      st_nxt.rx_data = {st_r.rxd_s3, st_r.lo_nib};
      st_nxt.rx_valid = st_r.lo_dv;
      st_nxt.rx_err = st_r.ctl_s3;
      st_nxt.rx_strobe = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.gtx_clk = st_r.gtx;
  assign lnk.tx_d = st_r.tx_d;
  assign lnk.tx_en_ctrl = st_r.tx_ctl;
  assign lnk.tx_er = st_r.tx_er;
  assign tx_take = st_r.tx_take;
  assign rx_data = st_r.rx_data;
  assign rx_valid = st_r.rx_valid;
  assign rx_err = st_r.rx_err;
  assign rx_strobe = st_r.rx_strobe;

endmodule

// >>> verification/phy_link_properties.sv
/* Timing checks on the wires between the transceiver end and the MAC end.
   Assumes one mclk domain, mode changed only in reset, all halves = HALF. */
module phy_link_properties #(
  parameter int HALF = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire phy_link_pkg::mode_e mode,
  input wire logic tx_clk,
  input wire logic gtx_clk,
  input wire logic rx_clk,
  input wire logic [7:0] tx_d,
  input wire logic tx_en_ctrl,
  input wire logic tx_er,
  input wire logic [3:0] rx_d,
  input wire logic rx_dv_ctrl
);
  import phy_link_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic mii;
  logic gmii;
  logic rgmii;
  logic [7:0] rx_cnt_r;
  logic rx_seen_r;
  assign mii = (mode == MODE_MII10) || (mode == MODE_MII100);
  assign gmii = mode == MODE_GMII;
  assign rgmii = mode == MODE_RGMII;
  // first half after reset is not measured: divider start is loose
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= 8'h00;
      rx_seen_r <= 1'b0;
    end else if ($changed(rx_clk)) begin
      rx_cnt_r <= 8'h00;
      rx_seen_r <= 1'b1;
    end else begin
      rx_cnt_r <= rx_cnt_r + 8'h01;
    end
  end
  sequence s_nib_quiet;
    $stable(tx_d[3:0]) && $stable(tx_en_ctrl) && $stable(tx_er);
  endsequence
  sequence s_byte_quiet;
    $stable(tx_d) && $stable(tx_en_ctrl) && $stable(tx_er);
  endsequence
  property p_tx_free;
    mii |-> ##[0:9] $changed(tx_clk);
  endproperty
  a_tx_free: assert property (p_tx_free)
    else $error("transmit clock stopped");
  property p_tx_rate;
    mii && $changed(tx_clk) |=> $stable(tx_clk)[*7] ##1 $changed(tx_clk);
  endproperty
  a_tx_rate: assert property (p_tx_rate)
    else $error("transmit clock half period wrong");
  property p_gtx_rate;
    $changed(gtx_clk) |=> $stable(gtx_clk)[*7] ##1 $changed(gtx_clk);
  endproperty
  a_gtx_rate: assert property (p_gtx_rate)
    else $error("gigabit clock half period wrong");
  property p_rx_rate;
    $changed(rx_clk) && rx_seen_r |-> rx_cnt_r == HALF - 1;
  endproperty
  a_rx_rate: assert property (p_rx_rate)
    else $error("receive clock half period wrong");
  property p_mii_capture;
    mii && $rose(tx_clk) |-> s_nib_quiet ##1 s_nib_quiet;
  endproperty
  a_mii_capture: assert property (p_mii_capture)
    else $error("transmit lanes moved at capture edge");
  property p_upper_idle;
    !gmii |-> tx_d[7:4] == 4'h0;
  endproperty
  a_upper_idle: assert property (p_upper_idle)
    else $error("upper transmit lanes active outside gigabit");
  property p_gmii_capture;
    gmii && $rose(gtx_clk) |-> s_byte_quiet ##1 s_byte_quiet;
  endproperty
  a_gmii_capture: assert property (p_gmii_capture)
    else $error("gigabit lanes moved at capture edge");
  property p_rgmii_tx;
    rgmii && ($changed(tx_d) || $changed(tx_en_ctrl))
      |-> $changed(gtx_clk) && !tx_er;
  endproperty
  a_rgmii_tx: assert property (p_rgmii_tx)
    else $error("reduced transmit lanes off clock edge");
  property p_rx_launch;
    !rgmii && ($changed(rx_d) || $changed(rx_dv_ctrl)) |-> $fell(rx_clk);
  endproperty
  a_rx_launch: assert property (p_rx_launch)
    else $error("receive lanes moved off falling edge");
  property p_rgmii_rx;
    rgmii && ($changed(rx_d) || $changed(rx_dv_ctrl)) |-> $changed(rx_clk);
  endproperty
  a_rgmii_rx: assert property (p_rgmii_rx)
    else $error("reduced receive lanes off clock edge");
endmodule

// >>> verification/tb.sv
/* Bench joining both link ends; random traffic in every mode.
   Assumes 100 MHz mclk and all link half periods set to H cycles. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_link_pkg::*;
  localparam int H = 8;
  logic mclk = 1'b0;
  logic rst_n, ce, tv, te, tt, rv, re, rt, ps, ms, mv, me, prev_er;
  logic [7:0] td, rd, ptd, mrd;
  sym_e psym;
  mode_e mode;
  mode_e modes[4] = '{MODE_MII10, MODE_MII100, MODE_GMII, MODE_RGMII};
  logic [10:0] txq[$];
  logic [9:0] rxq[$];
  logic [9:0] e;
  logic [7:0] msk;
  int num_errors = 0, comparisons = 0, k = 0, seed = 32'hefd7, nms = 0;
  phy_link_if lnk();
  phy_end #(.HALF10(H), .HALF100(H), .HALF1000(H)) i_phy_end (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .mode(mode), .lnk(lnk),
    .tx_data(ptd), .tx_sym(psym), .tx_strobe(ps), .rx_data(rd),
    .rx_valid(rv), .rx_err(re), .rx_take(rt));
  mac_end #(.HALF1000(H)) i_mac_end (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .mode(mode), .lnk(lnk),
    .tx_data(td), .tx_valid(tv), .tx_error(te), .tx_take(tt),
    .rx_data(mrd), .rx_valid(mv), .rx_err(me), .rx_strobe(ms));
  phy_link_properties #(.HALF(H)) i_props (
    .mclk(mclk), .rst_n(rst_n), .mode(mode), .tx_clk(lnk.tx_clk),
    .gtx_clk(lnk.gtx_clk), .rx_clk(lnk.rx_clk), .tx_d(lnk.tx_d),
    .tx_en_ctrl(lnk.tx_en_ctrl), .tx_er(lnk.tx_er), .rx_d(lnk.rx_d),
    .rx_dv_ctrl(lnk.rx_dv_ctrl));
  always #5 mclk = ~mclk;
  // nibble modes carry only the low half; repeated error becomes halt
  function automatic logic [10:0] exp_tx(mode_e m, logic [7:0] d,
                                          logic er, logic pe);
    logic n;
    n = (m == MODE_MII10) || (m == MODE_MII100);
    return {!er ? SYM_DATA : (n && pe) ? SYM_HALT : SYM_INVALID,
            n ? {4'h0, d[3:0]} : d};
  endfunction
  task automatic check(logic [10:0] got, logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rst_n && tt) begin
      if (tv || te)
        txq.push_back(exp_tx(mode, td, te, prev_er));
      prev_er = te;
      k++;
      td <= 8'($random(seed));
      tv <= ($random(seed) & 3) != 0;
      // forced error run so the halt follow-on is reached in both MII modes
      te <= (k >= 3 && k <= 6) || (($random(seed) & 3) == 0);
    end
    if (rst_n && rt) begin
      rxq.push_back({rv, (mode == MODE_RGMII) ? re : 1'b0, rd});
      rd <= 8'($random(seed));
      rv <= ($random(seed) & 3) != 0;
      re <= ($random(seed) & 7) == 0;
    end
    if (ps)
      check({psym, ptd}, txq.size() ? txq.pop_front() : 11'h7FF);
    // the first receive strobe after reset carries no launched unit
    if (ms)
      nms++;
    if (ms && nms > 1) begin
      e = rxq.size() ? rxq.pop_front() : 10'h3FF;
      msk = !e[9] ? 8'h00 : (mode == MODE_RGMII) ? 8'hFF : 8'h0F;
      check({mv, me, mrd & msk}, {e[9:8], e[7:0] & msk});
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    mode = MODE_MII10;
    {td, tv, te, rd, rv, re, prev_er} = {8'hFF, 2'b11, 8'hA5, 3'b110};
    foreach (modes[i]) begin
      rst_n <= 1'b0;
      mode <= modes[i];
      repeat (16) @(posedge mclk);
      txq.delete();
      rxq.delete();
      prev_er = 1'b0;
      k = 0;
      nms = 0;
      td <= 8'hFF;
      tv <= 1'b1;
      te <= 1'b1;
      rd <= 8'h00;
      rst_n <= 1'b1;
      repeat (700) @(posedge mclk);
      check({10'h0, k >= 40}, 11'h1);
    end
    give_verdict;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule
